/* hw/serbrg_pkg.sv */
// Purpose: constants shared by the serial rate generator files
// Assumes: 32-bit word-aligned register map on an AHB-Lite slave
// Notes: divisor pair forms a 16-bit count
`default_nettype none
package serbrg_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_TXCS = 8'h00;
   localparam logic [7:0] OFS_RXCS = 8'h04;
   localparam logic [7:0] OFS_RATE = 8'h08;
   localparam logic [7:0] OFS_DIVH = 8'h0c;
   localparam logic [7:0] OFS_DIVL = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   // transmit control fields
   localparam int TX_MASTER_BIT = 7;
   localparam int TX_SYNC_BIT = 4;
   localparam int TX_HSPEED_BIT = 2;
   localparam int TX_EMPTY_BIT = 1;
   // rate control fields
   localparam int RC_OVF_BIT = 7;
   localparam int RC_IDLE_BIT = 6;
   localparam int RC_WIDE_BIT = 3;
   // writable masks; unimplemented and status bits excluded
   localparam logic [7:0] TXCS_WMASK = 8'hfd;
   localparam logic [7:0] RXCS_WMASK = 8'hf8;
   localparam logic [7:0] RATE_WMASK = 8'hbb;
   // reset values
   localparam logic [7:0] TXCS_RST = 8'h02;
   localparam logic [7:0] RXCS_RST = 8'h00;
   localparam logic [7:0] RATE_RST = 8'h40;
   localparam logic [7:0] DIV_RST = 8'h00;
   // prescale shifts: 64, 16, 4 clocks per divisor period
   localparam logic [1:0] PRE_64 = 2'h3;
   localparam logic [1:0] PRE_16 = 2'h2;
   localparam logic [1:0] PRE_4 = 2'h1;
   typedef enum logic [1:0] {
      SERBRG_IDLE = 2'b00,
      SERBRG_DATA = 2'b01
   } serbrg_phase_t;
endpackage
`default_nettype wire

/* hw/serbrg_vote.sv */
// Purpose: three-sample majority vote of the receive input
// Assumes: input already synchronised to i_clk
// Notes: samples taken on each sample strobe
`default_nettype none
module serbrg_vote
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // sampling
   input wire logic i_smp,
   input wire logic i_rx,
   output logic o_level
);
   logic [2:0] smp_r;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         smp_r <= 3'h7;
         o_level <= 1'b1;
      end
      else if (i_smp)
      begin
         smp_r <= {smp_r[1:0], i_rx};
         o_level <= (smp_r[1] & smp_r[0]) | (smp_r[1] & i_rx) | (smp_r[0] & i_rx);
      end
   end
endmodule // serbrg_vote
`default_nettype wire

/* hw/serbrg_div.sv */
// Purpose: free-running divisor timer with prescaler
// Assumes: clear pulse from divisor writes
// Notes: tick once per (n+1) * 2^(2*pre) clocks
`default_nettype none
module serbrg_div
#(
   parameter int WIDTH = 16
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // control
   input wire logic i_clr,
   input wire logic [WIDTH-1:0] i_div,
   input wire logic [1:0] i_pre,
   output logic o_tick,
   output logic o_smp
);
   logic [5:0] pre_r;
   logic [WIDTH-1:0] cnt_r;
   logic pre_end;

   function automatic logic [5:0] pre_max(input logic [1:0] p);
      case (p)
         2'h3: pre_max = 6'h3f;
         2'h2: pre_max = 6'h0f;
         2'h1: pre_max = 6'h03;
         default: pre_max = 6'h00;
      endcase
   endfunction

   assign pre_end = (pre_r >= pre_max(i_pre));

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         pre_r <= 6'h00;
      else if (i_clr || pre_end)
         pre_r <= 6'h00;
      else
         pre_r <= pre_r + 6'h01;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cnt_r <= '0;
      else if (i_clr)
         cnt_r <= '0;
      else if (pre_end)
         cnt_r <= (cnt_r >= i_div) ? '0 : cnt_r + 1'b1;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_tick <= 1'b0;
         o_smp <= 1'b0;
      end
      else
      begin
         o_tick <= !i_clr && pre_end && (cnt_r >= i_div);
         o_smp <= !i_clr && pre_end;
      end
   end
endmodule // serbrg_div
`default_nettype wire

/* hw/serbrg_top.sv */
// Purpose: serial port rate generator with AHB-Lite register slave
// Assumes: 100 MHz i_clk is the device system clock
// Notes: rate generator, vote sampler and control registers only
// Notes on behaviour
// - bit rate is derived directly from the system clock
// - receive level decided by majority of three samples
// - async, 8-bit, low speed: clock over 64 times (n+1)
// - async, 16-bit, low speed: clock over 16 times (n+1)
// - divisor is high byte concatenated above low byte
// - rate control bit order: ovf, idle, dpol, cpol, wide, -, wake, auto
// - unimplemented bits read as zero
// - upper divisor bits live in their own high-byte register
// - wide enable clear uses low byte only, set uses both
// - divisor write clears the running timer at once; the code clears it one cycle after the write
// - sync slave takes bit clock from outside, no generated rate
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`default_nettype none
module serbrg_top
   import serbrg_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // ahb-lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // serial side
   input wire logic i_serial_receive_input,
   output logic o_rate_tick,
   output logic o_rx_level,
   output logic o_rate_active
);
   import serbrg_pkg::*;

   logic [7:0] txcs_r;
   logic [7:0] rxcs_r;
   logic [7:0] rate_r;
   logic [7:0] divh_r;
   logic [7:0] divl_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic rx_meta_r;
   logic rx_sync_r;
   logic div_clr_r;
   logic [15:0] div_val;
   logic [1:0] pre_sel;
   logic gen_on;
   logic tick;
   logic smp;
   logic level;
   logic addr_ph;
   logic [7:0] rd_byte;

   assign addr_ph = i_hsel && i_hready && i_htrans[1];

   // divisor selection
   assign div_val = rate_r[RC_WIDE_BIT] ? {divh_r, divl_r} : {8'h00, divl_r};

   // prescale by mode
   always_comb
   begin
      if (txcs_r[TX_SYNC_BIT])
         pre_sel = PRE_4;
      else if (rate_r[RC_WIDE_BIT] && txcs_r[TX_HSPEED_BIT])
         pre_sel = PRE_4;
      else if (rate_r[RC_WIDE_BIT] || txcs_r[TX_HSPEED_BIT])
         pre_sel = PRE_16;
      else
         pre_sel = PRE_64;
   end

   // sync slave: no generated rate
   assign gen_on = !txcs_r[TX_SYNC_BIT] || txcs_r[TX_MASTER_BIT];

   serbrg_div #(
      .WIDTH(16)
   ) u_div (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_clr(div_clr_r || !gen_on),
      .i_div(div_val),
      .i_pre(pre_sel),
      .o_tick(tick),
      .o_smp(smp)
   );

   // receive pin synchroniser
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end
      else
      begin
         rx_meta_r <= i_serial_receive_input;
         rx_sync_r <= rx_meta_r;
      end
   end

   serbrg_vote u_vote (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_smp(smp),
      .i_rx(rx_sync_r),
      .o_level(level)
   );

   // address phase capture
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end
      else
      begin
         wr_pend_r <= addr_ph && i_hwrite;
         if (addr_ph)
            wr_addr_r <= i_haddr[7:0];
      end
   end

   // register writes
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         txcs_r <= TXCS_RST;
         rxcs_r <= RXCS_RST;
         rate_r <= RATE_RST;
         divh_r <= DIV_RST;
         divl_r <= DIV_RST;
      end
      else if (wr_pend_r)
      begin
         case (wr_addr_r)
            OFS_TXCS: txcs_r <= (i_hwdata[7:0] & TXCS_WMASK) | (txcs_r & ~TXCS_WMASK);
            OFS_RXCS: rxcs_r <= i_hwdata[7:0] & RXCS_WMASK;
            OFS_RATE: rate_r <= (i_hwdata[7:0] & RATE_WMASK) | (rate_r & ~RATE_WMASK);
            OFS_DIVH: divh_r <= i_hwdata[7:0];
            OFS_DIVL: divl_r <= i_hwdata[7:0];
            default: txcs_r <= txcs_r;
         endcase
      end
   end

   // divisor write clears timer next cycle
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         div_clr_r <= 1'b0;
      else
         div_clr_r <= wr_pend_r && (wr_addr_r == OFS_DIVH || wr_addr_r == OFS_DIVL);
   end

   // read mux
   always_comb
   begin
      case (i_haddr[7:0])
         OFS_TXCS: rd_byte = txcs_r;
         OFS_RXCS: rd_byte = rxcs_r;
         OFS_RATE: rd_byte = rate_r & 8'hfb;
         OFS_DIVH: rd_byte = divh_r;
         OFS_DIVL: rd_byte = divl_r;
         OFS_STAT: rd_byte = {6'h00, level, gen_on};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_hrdata <= 32'h0000_0000;
      else if (addr_ph && !i_hwrite)
         o_hrdata <= {24'h000000, rd_byte};
   end

   // always ready, always okay
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
      else
      begin
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
   end

   // serial outputs
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_rate_tick <= 1'b0;
         o_rx_level <= 1'b1;
         o_rate_active <= 1'b0;
      end
      else
      begin
         o_rate_tick <= tick && gen_on;
         o_rx_level <= level;
         o_rate_active <= gen_on;
      end
   end
endmodule // serbrg_top
`default_nettype wire

/* verif/serbrg_chk.sv */
// Purpose: port checker for the rate generator
// Assumes: one clock domain
// Notes: bound to serbrg_top
`default_nettype none
module serbrg_chk
   import serbrg_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // bus
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic i_hready,
   input wire logic [31:0] o_hrdata,
   // serial
   input wire logic i_serial_receive_input,
   input wire logic o_rate_tick,
   input wire logic o_rx_level,
   input wire logic o_rate_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   logic ap, rd, wdiv, hold, rx_q_r;
   logic [7:0] ad;
   logic [9:0] st_r;
   assign ap = i_hsel & i_hready & i_htrans[1];
   assign rd = ap & ~i_hwrite;
   assign ad = i_haddr[7:0];
   assign wdiv = ap & i_hwrite & (ad == OFS_DIVL || ad == OFS_DIVH);
   assign hold = rx_q_r == i_serial_receive_input && o_rate_active;
   // stable-input cycle count, saturating
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rx_q_r <= 1'b1;
         st_r <= 10'h0;
      end
      else
      begin
         rx_q_r <= i_serial_receive_input;
         st_r <= hold ? st_r + {9'h0, ~&st_r} : 10'h0;
      end
   end
   property p_upper; rd |=> o_hrdata[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper bits set");
   property p_rsvd; rd && ad == OFS_RATE |=> !o_hrdata[2]; endproperty
   a_rsvd: assert property (p_rsvd) else $error("bit 2 set");
   property p_tact; o_rate_tick |-> o_rate_active; endproperty
   a_tact: assert property (p_tact) else $error("tick while off");
   property p_gap; o_rate_tick |=> !o_rate_tick [*3]; endproperty
   a_gap: assert property (p_gap) else $error("ticks too close");
   property p_clr; wdiv |-> ##4 !o_rate_tick [*2]; endproperty
   a_clr: assert property (p_clr) else $error("timer not cleared");
   property p_vote; st_r == 10'h3ff |-> o_rx_level == rx_q_r; endproperty
   a_vote: assert property (p_vote) else $error("level wrong");
   property p_slvl; rd && ad == OFS_STAT |=> o_hrdata[1] == o_rx_level; endproperty
   a_slvl: assert property (p_slvl) else $error("status level");
   property p_son; rd && ad == OFS_STAT |=> o_hrdata[0] == o_rate_active; endproperty
   a_son: assert property (p_son) else $error("status on");
   c_tick: cover property (o_rate_tick);
   c_wdiv: cover property (wdiv);
   c_vote: cover property (st_r == 10'h3ff);
endmodule // serbrg_chk
bind serbrg_top serbrg_chk chk_u (.*);
`default_nettype wire

/* verif/serbrg_peer.sv */
// Purpose: serial peer on the receive line
// Assumes: idle-high line, bit time in clocks
// Notes: start bit, eight data bits lsb first, stop bit
`default_nettype none
module serbrg_peer
(
   // clock
   input wire logic i_clk,
   // line
   output logic o_line
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_line = 1'b1;
   task automatic send(input logic [7:0] b, input int bt);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         o_line <= f[i];
         repeat (bt) @(posedge i_clk);
      end
   endtask
endmodule // serbrg_peer
`default_nettype wire

/* verif/testbench.sv */
// Purpose: self-checking bench for the rate generator
// Assumes: zero wait-state slave
// Notes: reads and tick gaps checked from queues
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import serbrg_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, hw = 1'b0, rd_dp = 1'b0, rdy, resp, tick, lvl, act, rx;
   logic [1:0] ht = 2'h0;
   logic [31:0] ha = 32'h0, wd = 32'h0, hr;
   logic [7:0] r;
   logic [9:0] f;
   int mismatches = 0, n_tests = 0, meas = 0, gap = 0, k;
   logic [31:0] q_rd[$];
   int q_p[$];
   always #5 clk = ~clk;
   serbrg_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(1'b1), .i_haddr(ha), .i_htrans(ht),
      .i_hwrite(hw), .i_hsize(3'h2), .i_hwdata(wd), .i_hready(rdy), .o_hrdata(hr),
      .o_hreadyout(rdy), .o_hresp(resp), .i_serial_receive_input(rx), .o_rate_tick(tick),
      .o_rx_level(lvl), .o_rate_active(act));
   serbrg_peer peer_u (.i_clk(clk), .o_line(rx));
   task automatic finish_test();
      $display("checks %0d, wrong %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic hang();
      mismatches++;
      $display("wrong value at %0t: timeout", $time);
      finish_test();
   endtask
   task automatic cmp_rd(input logic [31:0] e);
      n_tests++;
      if (hr !== e || resp !== 1'b0)
      begin
         mismatches++;
         $display("wrong value at %0t: read %h", $time, hr);
      end
   endtask
   task automatic cmp_p(input int e);
      n_tests++;
      if (gap != e)
      begin
         mismatches++;
         $display("wrong value at %0t: period %0d", $time, gap);
      end
   endtask
   // result watcher
   always @(posedge clk)
   begin
      if (rd_dp)
         cmp_rd(q_rd.pop_front());
      rd_dp <= ht[1] && !hw && rdy;
      gap <= tick ? 1 : gap + 1;
      if (tick && meas == 1)
         cmp_p(q_p.pop_front());
      if (tick && meas > 0)
         meas <= meas - 1;
   end
   task automatic wrdy();
      @(posedge clk);
      for (k = 0; k < 50 && rdy !== 1'b1; k++)
         @(posedge clk);
      if (k == 50)
         hang();
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      ht <= 2'h2;
      ha <= {24'h0, a};
      hw <= w;
      wrdy();
      ht <= 2'h0;
      wd <= d;
      wrdy();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q_rd.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic mode(input logic [7:0] tx, rc, dl, input int p);
      bus(1'b1, OFS_TXCS, {24'h0, tx});
      bus(1'b1, OFS_RATE, {24'h0, rc});
      bus(1'b1, OFS_DIVH, 32'h1);
      bus(1'b1, OFS_DIVL, {24'h0, dl});
      q_p.push_back(p);
      meas <= 2;
      @(posedge clk);
      for (k = 0; k < 9000 && meas != 0; k++)
         @(posedge clk);
      if (k == 9000)
         hang();
      $display("test done: period %0d", p);
   endtask
   initial
   begin
      void'($urandom(32'h8da8));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_TXCS, 32'h2);
      rd(OFS_RATE, 32'h40);
      rd(OFS_DIVL, 32'h0);
      bus(1'b1, OFS_RATE, 32'h3f);
      rd(OFS_RATE, 32'h7b);
      bus(1'b1, OFS_RXCS, 32'hff);
      rd(OFS_RXCS, 32'hf8);
      bus(1'b1, 8'h18, 32'hff);
      rd(8'h18, 32'h0);
      bus(1'b1, OFS_DIVH, 32'ha5);
      rd(OFS_DIVH, 32'ha5);
      $display("test done: registers");
      mode(8'h00, 8'h00, 8'h02, 192);
      mode(8'h04, 8'h00, 8'h02, 48);
      mode(8'h00, 8'h08, 8'h02, 4144);
      mode(8'h04, 8'h08, 8'h02, 1036);
      mode(8'h90, 8'h00, 8'h02, 12);
      mode(8'h94, 8'h00, 8'h02, 12);
      r = 8'($urandom % 8);
      mode(8'h04, 8'h00, r, 16 * (r + 1));
      bus(1'b1, OFS_TXCS, 32'h10);
      repeat (4) @(posedge clk);
      rd(OFS_STAT, 32'h2);
      bus(1'b1, OFS_TXCS, 32'h0);
      f = {1'b1, 8'($urandom), 1'b0};
      fork
         peer_u.send(f[8:1], 512);
         for (int i = 0; i < 10; i++)
         begin
            repeat (i == 0 ? 400 : 510) @(posedge clk);
            rd(OFS_STAT, {30'h0, f[i], 1'b1});
         end
      join
      $display("test done: frame");
      finish_test();
   end
endmodule // testbench
`default_nettype wire
